// [include/pcx_pkg.sv]
package pcx_pkg;

    // ------------------------------------------------------------
    // internal register index decode
    // ------------------------------------------------------------
    localparam int          IDX_W          = 8;
    localparam int          IDX_SEL_HI     = 7;
    localparam int          IDX_SEL_LO     = 6;
    localparam logic [1:0]  IDX_SEL_CTX    = 2'h1;
    localparam int          IDX_FLD_ASN    = 0;
    localparam int          IDX_FLD_TEN    = 1;
    localparam int          IDX_FLD_TRQ    = 2;
    localparam int          IDX_FLD_PCE    = 3;
    localparam int          IDX_FLD_FPE    = 4;
    // pseudo register indices, values arbitrary within the other index space
    localparam logic [7:0]  IDX_ICACHE_FULL = 8'h10;
    localparam logic [7:0]  IDX_ICACHE_SEL  = 8'h11;
    localparam logic [7:0]  IDX_MAP_CLEAR   = 8'h12;
    localparam logic [7:0]  IDX_SLEEP       = 8'h13;

    // ------------------------------------------------------------
    // process context field layout
    // ------------------------------------------------------------
    localparam int          DATA_W     = 64;
    localparam int          ASN_HI     = 46;
    localparam int          ASN_LO     = 39;
    localparam int          TRQ_HI     = 12;
    localparam int          TRQ_LO     = 9;
    localparam int          TEN_HI     = 8;
    localparam int          TEN_LO     = 5;
    localparam int          FPE_BIT    = 2;
    localparam int          PCE_BIT    = 1;
    localparam logic        FPE_RESET  = 1'b1;
    localparam logic [7:0]  ASN_RESET  = 8'h00;
    localparam logic [3:0]  TRAP_RESET = 4'h0;
    localparam logic        PCE_RESET  = 1'b0;

    // mode encoding: kernel 0 .. user 3, index into the four-bit trap fields
    localparam int          MODE_W     = 2;
    localparam int          NUM_MODES  = 4;

    typedef enum {
        PCX_IDLE,
        PCX_FLUSH_PEND
    } pcx_flush_e;

endpackage : pcx_pkg

// [include/pcx_ctx_if.sv]
`timescale 1ns/1ps
// context fields shared between the register bank and trap evaluator
interface pcx_ctx_if;
    logic [3:0] trap_req;
    logic [3:0] trap_en;
    logic       global_en;
    logic [1:0] cur_mode;
    logic [3:0] pending;

    modport bank (output trap_req, output trap_en, output global_en,
                  output cur_mode, input pending);
    modport eval (input trap_req, input trap_en, input global_en,
                  input cur_mode, output pending);
endinterface : pcx_ctx_if

// [verilog/pcx_trap_eval.sv]
`timescale 1ns/1ps
module pcx_trap_eval
    import pcx_pkg::*;
(
    pcx_ctx_if.eval ctx
);

    // ------------------------------------------------------------
    // trap qualification
    // ------------------------------------------------------------
    // request, enable and global enable all set; current mode at or above
    always_comb begin
        for (int m = 0; m < NUM_MODES; m++) begin
            ctx.pending[m] = ctx.trap_req[m] & ctx.trap_en[m] & ctx.global_en
                           & (ctx.cur_mode >= MODE_W'(m));
        end
    end

endmodule : pcx_trap_eval

// [verilog/pcx_flush_ctl.sv]
`timescale 1ns/1ps
module pcx_flush_ctl
    import pcx_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic full_req,
    input  wire logic retire_point,
    output logic      flush_all
);

    pcx_flush_e state_reg;

    // ------------------------------------------------------------
    // deferred full flush
    // ------------------------------------------------------------
    // held until the next privileged return retires, so the flush
    // lands on a clean fetch boundary
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= PCX_IDLE;
        end else begin
            unique case (state_reg)
                PCX_IDLE: begin
                    if (full_req && !retire_point) state_reg <= PCX_FLUSH_PEND;
                end
                PCX_FLUSH_PEND: begin
                    if (retire_point) state_reg <= PCX_IDLE;
                end
            endcase
        end
    end

    // a request and a retire in the same cycle flush at once
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flush_all <= 1'b0;
        end else begin
            flush_all <= retire_point && (full_req || state_reg == PCX_FLUSH_PEND);
        end
    end

endmodule : pcx_flush_ctl

// [verilog/pcx_process_context.sv]
`timescale 1ns/1ps
// Functional notes
// - full icache flush write invalidates all blocks at next return or stall retire; here only privileged_return retires it, there is no stall input.
// - selective flush invalidates only blocks whose address space match bit is clear.
// - rename map clear write resets architectural to physical register mapping.
// - sleep write lowers the pll rate and enters low power.
// - context register selected when index bits 7:6 equal binary 01.
// - index bits 4:0 pick which context fields a write updates.
// - a read returns all context fields together.
// - trap needs request bit, enable bit and global trap enable all set.
// - trap also needs current mode at or above the request's mode.
// - trap requests at bits 12:9, user 12 down to kernel 9.
// - trap enables at bits 8:5, user 8 down to kernel 5.
// - with float enable clear, float instructions fault instead of executing.
// - float enable is set to one at reset.
// - process counting enable gates counters zero and one per their own enables.
// - system counting enable also lets counters count, independent of process.
// - address space number at bits 46:39; listed ranges reserved.
module pcx_process_context
    import pcx_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              privileged_reg_write,
    input  wire logic              privileged_reg_read,
    input  wire logic [IDX_W-1:0]  internal_reg_index,
    input  wire logic [DATA_W-1:0] write_data,
    output logic      [DATA_W-1:0] read_data,
    output logic                   read_hit,
    input  wire logic              privileged_return,
    input  wire logic              async_trap_global_enable,
    input  wire logic [MODE_W-1:0] processor_status,
    input  wire logic              float_instr_valid,
    output logic                   float_instr_issue,
    output logic                   float_disabled_fault,
    input  wire logic              system_counting_enable,
    input  wire logic              counter0_enable,
    input  wire logic              counter1_enable,
    output logic                   perf_counter_zero_count_en,
    output logic                   perf_counter_one_count_en,
    output logic [3:0]             async_trap_pending,
    output logic                   icache_flush_all,
    output logic                   icache_selective_invalidate,
    output logic                   rename_map_clear,
    output logic                   sleep_enter,
    output logic                   pll_slow
);

    // ------------------------------------------------------------
    // field storage
    // ------------------------------------------------------------
    logic [7:0] address_space_number_reg;
    logic [3:0] async_trap_enables_reg;
    logic [3:0] async_trap_requests_reg;
    logic       process_counting_enable_reg;
    logic       float_enable_reg;
    logic       ctx_sel;
    logic       full_req;

    pcx_ctx_if ctx ();

    // ------------------------------------------------------------
    // index decode
    // ------------------------------------------------------------
    function automatic logic is_pseudo(input logic [IDX_W-1:0] idx,
                                       input logic [IDX_W-1:0] code);
        return idx == code;
    endfunction : is_pseudo

    assign ctx_sel  = internal_reg_index[IDX_SEL_HI:IDX_SEL_LO] == IDX_SEL_CTX;
    assign full_req = privileged_reg_write && is_pseudo(internal_reg_index, IDX_ICACHE_FULL);

    // ------------------------------------------------------------
    // context field writes
    // ------------------------------------------------------------
    // each field has its own select bit; unselected fields hold
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            address_space_number_reg <= ASN_RESET;
        end else if (privileged_reg_write && ctx_sel
                     && internal_reg_index[IDX_FLD_ASN]) begin
            address_space_number_reg <= write_data[ASN_HI:ASN_LO];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            async_trap_enables_reg <= TRAP_RESET;
        end else if (privileged_reg_write && ctx_sel
                     && internal_reg_index[IDX_FLD_TEN]) begin
            async_trap_enables_reg <= write_data[TEN_HI:TEN_LO];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            async_trap_requests_reg <= TRAP_RESET;
        end else if (privileged_reg_write && ctx_sel
                     && internal_reg_index[IDX_FLD_TRQ]) begin
            async_trap_requests_reg <= write_data[TRQ_HI:TRQ_LO];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            process_counting_enable_reg <= PCE_RESET;
        end else if (privileged_reg_write && ctx_sel
                     && internal_reg_index[IDX_FLD_PCE]) begin
            process_counting_enable_reg <= write_data[PCE_BIT];
        end
    end

    // float enable comes out of reset set
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            float_enable_reg <= FPE_RESET;
        end else if (privileged_reg_write && ctx_sel
                     && internal_reg_index[IDX_FLD_FPE]) begin
            float_enable_reg <= write_data[FPE_BIT];
        end
        // unselected fields fall through and hold
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // registered; reserved bits stay zero, writes to them are dropped
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            read_data <= '0;
            read_hit  <= 1'b0;
        end else begin
            read_hit  <= privileged_reg_read && ctx_sel;
            read_data <= '0;
            if (privileged_reg_read && ctx_sel) begin
                read_data[ASN_HI:ASN_LO] <= address_space_number_reg;
                read_data[TRQ_HI:TRQ_LO] <= async_trap_requests_reg;
                read_data[TEN_HI:TEN_LO] <= async_trap_enables_reg;
                read_data[FPE_BIT]       <= float_enable_reg;
                read_data[PCE_BIT]       <= process_counting_enable_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // pseudo register strobes
    // ------------------------------------------------------------
    // one-cycle pulses; map clear relies on software draining first
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            icache_selective_invalidate <= 1'b0;
            rename_map_clear            <= 1'b0;
            sleep_enter                 <= 1'b0;
        end else begin
            icache_selective_invalidate <= privileged_reg_write
                && is_pseudo(internal_reg_index, IDX_ICACHE_SEL);
            rename_map_clear            <= privileged_reg_write
                && is_pseudo(internal_reg_index, IDX_MAP_CLEAR);
            sleep_enter                 <= privileged_reg_write
                && is_pseudo(internal_reg_index, IDX_SLEEP);
        end
    end

    // pll stays slow until reset; wake sequencing lives elsewhere
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pll_slow <= 1'b0;
        end else if (privileged_reg_write && is_pseudo(internal_reg_index, IDX_SLEEP)) begin
            pll_slow <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // full flush deferral
    // ------------------------------------------------------------
    pcx_flush_ctl u_flush (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .full_req     (full_req),
        .retire_point (privileged_return),
        .flush_all    (icache_flush_all)
    );

    // ------------------------------------------------------------
    // async trap evaluation
    // ------------------------------------------------------------
    assign ctx.trap_req  = async_trap_requests_reg;
    assign ctx.trap_en   = async_trap_enables_reg;
    assign ctx.global_en = async_trap_global_enable;
    assign ctx.cur_mode  = processor_status;

    pcx_trap_eval u_trap (
        .ctx (ctx.eval)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            async_trap_pending <= '0;
        end else begin
            async_trap_pending <= ctx.pending;
        end
    end

    // ------------------------------------------------------------
    // float gating
    // ------------------------------------------------------------
    // combinational so a disabled op never reaches execution
    assign float_instr_issue    = float_instr_valid && float_enable_reg;
    assign float_disabled_fault = float_instr_valid && !float_enable_reg;

    // ------------------------------------------------------------
    // performance count enables
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            perf_counter_zero_count_en <= 1'b0;
            perf_counter_one_count_en  <= 1'b0;
        end else begin
            perf_counter_zero_count_en <= counter0_enable
                && (process_counting_enable_reg || system_counting_enable);
            perf_counter_one_count_en  <= counter1_enable
                && (process_counting_enable_reg || system_counting_enable);
        end
    end

endmodule : pcx_process_context

// [tb/pcx_props_properties.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// port-level checks for the process context bank
// ------------------------------------------------------------
module pcx_props
    import pcx_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic              privileged_reg_write,
    input wire logic              privileged_reg_read,
    input wire logic [IDX_W-1:0]  internal_reg_index,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic              read_hit,
    input wire logic              privileged_return,
    input wire logic              async_trap_global_enable,
    input wire logic [MODE_W-1:0] processor_status,
    input wire logic              float_instr_valid,
    input wire logic              float_instr_issue,
    input wire logic              float_disabled_fault,
    input wire logic              system_counting_enable,
    input wire logic              counter0_enable,
    input wire logic              perf_counter_zero_count_en,
    input wire logic [3:0]        async_trap_pending,
    input wire logic              icache_flush_all,
    input wire logic              icache_selective_invalidate,
    input wire logic              rename_map_clear,
    input wire logic              sleep_enter,
    input wire logic              pll_slow
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // selective flush, map clear and sleep writes answer one cycle later
    property p_sel_flush;
        privileged_reg_write && internal_reg_index == IDX_ICACHE_SEL |=> icache_selective_invalidate;
    endproperty
    a_sel_flush: assert property (p_sel_flush) else $error("selective flush missing");
    property p_map_clear;
        privileged_reg_write && internal_reg_index == IDX_MAP_CLEAR |=> rename_map_clear;
    endproperty
    a_map_clear: assert property (p_map_clear) else $error("map clear missing");
    property p_sleep;
        privileged_reg_write && internal_reg_index == IDX_SLEEP |=> sleep_enter && pll_slow;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry missing");
    // slow clock is sticky until reset, no wake path here
    property p_pll_hold;
        pll_slow |=> pll_slow;
    endproperty
    a_pll_hold: assert property (p_pll_hold) else $error("slow clock dropped");
    // full flush only lands behind a retiring return
    property p_flush_at_ret;
        icache_flush_all |-> $past(privileged_return);
    endproperty
    a_flush_at_ret: assert property (p_flush_at_ret) else $error("flush without return");
    property p_read;
        privileged_reg_read && internal_reg_index[7:6] == IDX_SEL_CTX |=> read_hit
            && read_data[63:47] == '0 && read_data[38:13] == '0 && read_data[4:3] == '0
            && !read_data[0];
    endproperty
    a_read: assert property (p_read) else $error("context read bad");
    property p_fault;
        float_disabled_fault |-> float_instr_valid && !float_instr_issue;
    endproperty
    a_fault: assert property (p_fault) else $error("fault and issue clash");
    property p_trap_global;
        async_trap_pending != 4'h0 |-> $past(async_trap_global_enable);
    endproperty
    a_trap_global: assert property (p_trap_global) else $error("trap without global");
    property p_trap_mode;
        async_trap_pending[3] |-> $past(processor_status) == 2'h3;
    endproperty
    a_trap_mode: assert property (p_trap_mode) else $error("user trap wrong mode");
    property p_sys_count;
        system_counting_enable && counter0_enable |=> perf_counter_zero_count_en;
    endproperty
    a_sys_count: assert property (p_sys_count) else $error("system count missing");
    property p_cnt_gate;
        perf_counter_zero_count_en |-> $past(counter0_enable);
    endproperty
    a_cnt_gate: assert property (p_cnt_gate) else $error("counter ran disabled");

    c_flush: cover property (icache_flush_all);
    c_read: cover property (read_hit);
    c_trap: cover property (async_trap_pending != 4'h0);
endmodule : pcx_props

// [tb/test_pcx_process_context.sv]
`timescale 1ns/1ps
module test_pcx_process_context
    import pcx_pkg::*;
;
    logic              core_clk, arst_n, privileged_reg_write, privileged_reg_read;
    logic              privileged_return, async_trap_global_enable, float_instr_valid;
    logic              system_counting_enable, counter0_enable, counter1_enable;
    logic [IDX_W-1:0]  internal_reg_index;
    logic [DATA_W-1:0] write_data, read_data;
    logic [MODE_W-1:0] processor_status;
    logic              read_hit, float_instr_issue, float_disabled_fault, icache_flush_all;
    logic              perf_counter_zero_count_en, perf_counter_one_count_en, pll_slow;
    logic              icache_selective_invalidate, rename_map_clear, sleep_enter;
    logic [3:0]        async_trap_pending, m_trq, m_ten, e;
    logic [7:0]        m_asn;
    logic              m_pce, m_fpe;
    logic [DATA_W-1:0] exp_q[$];
    int                fails, checks, cycles;

    pcx_process_context pcx_process_context_inst (
        .core_clk, .arst_n, .privileged_reg_write, .privileged_reg_read,
        .internal_reg_index, .write_data, .read_data, .read_hit, .privileged_return,
        .async_trap_global_enable, .processor_status, .float_instr_valid,
        .float_instr_issue, .float_disabled_fault, .system_counting_enable,
        .counter0_enable, .counter1_enable, .perf_counter_zero_count_en,
        .perf_counter_one_count_en, .async_trap_pending, .icache_flush_all,
        .icache_selective_invalidate, .rename_map_clear, .sleep_enter, .pll_slow
    );

    // ------------------------------------------------------------
    // helpers: wr, rd and idle start and end 1 ns after a rising edge; check and wrap_up take no time
    // ------------------------------------------------------------
    task automatic check(logic [DATA_W-1:0] seen, logic [DATA_W-1:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic wrap_up();
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [DATA_W-1:0] ctx_val();
        ctx_val = '0;
        ctx_val[ASN_HI:ASN_LO] = m_asn;
        ctx_val[TRQ_HI:TRQ_LO] = m_trq;
        ctx_val[TEN_HI:TEN_LO] = m_ten;
        ctx_val[FPE_BIT] = m_fpe;
        ctx_val[PCE_BIT] = m_pce;
    endfunction : ctx_val

    // strobe left high so back-to-back calls never toggle it in one step
    task automatic wr(logic [7:0] idx, logic [DATA_W-1:0] d);
        internal_reg_index = idx;
        write_data = d;
        privileged_reg_read = 1'b0;
        privileged_reg_write = 1'b1;
        @(posedge core_clk) #1;
        if (idx[7:6] == IDX_SEL_CTX) begin
            if (idx[IDX_FLD_ASN]) m_asn = d[ASN_HI:ASN_LO];
            if (idx[IDX_FLD_TEN]) m_ten = d[TEN_HI:TEN_LO];
            if (idx[IDX_FLD_TRQ]) m_trq = d[TRQ_HI:TRQ_LO];
            if (idx[IDX_FLD_PCE]) m_pce = d[PCE_BIT];
            if (idx[IDX_FLD_FPE]) m_fpe = d[FPE_BIT];
        end
    endtask : wr

    task automatic rd(logic [7:0] idx);
        internal_reg_index = idx;
        write_data = {$urandom, $urandom};
        privileged_reg_write = 1'b0;
        privileged_reg_read = 1'b1;
        if (idx[7:6] == IDX_SEL_CTX) exp_q.push_back(ctx_val());
        @(posedge core_clk) #1;
    endtask : rd

    task automatic idle(int n);
        privileged_reg_write = 1'b0;
        privileged_reg_read = 1'b0;
        repeat (n) @(posedge core_clk) #1;
    endtask : idle

    // read results checked mid-cycle, well clear of the launching edge
    always @(negedge core_clk) begin
        if (read_hit === 1'b1) begin
            check(read_data, exp_q.size() ? exp_q.pop_front() : 'x);
        end
    end

    // hang guard, far above the 184 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {arst_n, privileged_reg_write, privileged_reg_read, privileged_return} = '0;
        {async_trap_global_enable, float_instr_valid, system_counting_enable} = '0;
        {counter0_enable, counter1_enable, internal_reg_index, write_data} = '0;
        processor_status = '0;
        {m_asn, m_trq, m_ten, m_pce, m_fpe} = '0;
        m_fpe = FPE_RESET;
        void'($urandom(12516));
        repeat (20) @(posedge core_clk);
        #1 arst_n = 1'b1;
        rd(8'h40);
        float_instr_valid = 1'b1;
        idle(1);
        check(float_disabled_fault, 1'b0);
        wr(8'h50, '0);
        check(float_disabled_fault, 1'b1);
        check(float_instr_issue, 1'b0);
        wr(8'h50, 64'h0000_0000_0000_0004);
        for (int i = 0; i < 40; i++) begin
            wr({(i % 3 == 0) ? 2'($urandom) : IDX_SEL_CTX, 6'($urandom)}, {$urandom, $urandom});
            rd({IDX_SEL_CTX, 6'($urandom)});
        end
        rd(8'h80);
        for (int j = 0; j < 4; j++) begin
            wr(8'h46, {$urandom, $urandom});
            for (int k = 0; k < 8; k++) begin
                processor_status = k[1:0];
                async_trap_global_enable = k[2];
                idle(1);
                for (int m = 0; m < NUM_MODES; m++) e[m] = m_trq[m] & m_ten[m] & k[2] & (k[1:0] >= m);
                check(async_trap_pending, e);
            end
        end
        for (int k = 0; k < 16; k++) begin
            {system_counting_enable, counter0_enable, counter1_enable} = k[2:0];
            wr(8'h48, {62'h0, k[3], 1'b0});
            idle(1);
            check(perf_counter_zero_count_en, counter0_enable & (m_pce | k[2]));
            check(perf_counter_one_count_en, counter1_enable & (m_pce | k[2]));
        end
        wr(IDX_ICACHE_SEL, '0);
        check(icache_selective_invalidate, 1'b1);
        // bench has nothing in flight, so a map clear is legal here
        wr(IDX_MAP_CLEAR, '0);
        check(rename_map_clear, 1'b1);
        check(icache_selective_invalidate, 1'b0);
        // no state to save and no caches to drain before sleep here
        wr(IDX_SLEEP, '0);
        check({sleep_enter, pll_slow}, 2'h3);
        wr(IDX_ICACHE_FULL, '0);
        idle(2);
        check(icache_flush_all, 1'b0);
        privileged_return = 1'b1;
        @(posedge core_clk) #1;
        privileged_return = 1'b0;
        check(icache_flush_all, 1'b1);
        idle(1);
        check(icache_flush_all, 1'b0);
        // request and retire in one cycle flush on the next edge
        privileged_return = 1'b1;
        wr(IDX_ICACHE_FULL, '0);
        privileged_return = 1'b0;
        check(icache_flush_all, 1'b1);
        idle(2);
        check(icache_flush_all, 1'b0);
        check(exp_q.size(), 0);
        wrap_up();
    end
endmodule : test_pcx_process_context

bind pcx_process_context pcx_props pcx_props_inst (
    .core_clk, .arst_n, .privileged_reg_write, .privileged_reg_read, .internal_reg_index,
    .read_data, .read_hit, .privileged_return, .async_trap_global_enable, .processor_status,
    .float_instr_valid, .float_instr_issue, .float_disabled_fault, .system_counting_enable,
    .counter0_enable, .perf_counter_zero_count_en, .async_trap_pending, .icache_flush_all,
    .icache_selective_invalidate, .rename_map_clear, .sleep_enter, .pll_slow
);
